// ==== core/lfm_fault_monitor.sv ====
`timescale 1ns/1ps
// Function
// - Over-current status held about 50 us by a retriggerable hold timer.
// - Over-current hold expiring with comparator clear resets fault counter.
// - Short circuit above 1000 mV kills drives at once and flags fault.
// - Short-circuit detection active from reset release, start-up included.
// - Voltage sense at 2 V enables clamp pulling error amp node down.
// - Error amp node below 0.5 V disables all gate drives.
// - Undervoltage input below 0.4 V counts; full count reports fault.
// - Counter reset at cycle 32768, then every 65536 cycles.
// - Voltage fault held 50 us; counter cleared if gone at expiry.
// - Counter reaching 256 confirms fault, fault indicator driven low.
// - Counter advances on the drive switching clock.
// - Over-current counting starts when current sense exceeds 630 mV.
module lfm_fault_monitor
    import lfm_pkg::*;
(
    input  wire logic clk,               // Drive switching rate clock
    input  wire logic reset,             // Power-on reset, active high
    input  wire logic cmp_oc,            // Current sense above 630 mV
    input  wire logic cmp_sc,            // Current sense above 1000 mV
    input  wire logic cmp_ov,            // Voltage sense at 2 V
    input  wire logic cmp_uv,            // Undervoltage input below 0.4 V
    input  wire logic cmp_comp_low,      // Error amp node below 0.5 V
    input  wire logic drive_in_first,    // Drive request, first output
    input  wire logic drive_in_second,   // Drive request, second output
    output logic      drive_out_first,   // Gated first drive output
    output logic      drive_out_second,  // Gated second drive output
    output logic      clamp_enable,      // Clamp current source on
    output logic      fault_n            // Fault indicator, active low
);
    logic oc_s;
    logic sc_s;
    logic ov_s;
    logic uv_s;
    logic cl_s;
    logic [HOLD_W-1:0]  oc_hold_q;
    logic [HOLD_W-1:0]  ov_hold_q;
    logic [SCHED_W-1:0] sched_q;
    logic               first_done_q;
    logic [FCNT_W-1:0]  fcnt_q;
    logic               fault_q;
    logic               sc_trip_q;
    logic               oc_expire;
    logic               ov_expire;
    logic               sched_rst;
    logic               oc_held;
    logic               ov_held;

    // Full count is decoded in several places, so it is decoded once
    function automatic logic count_full(input logic [FCNT_W-1:0] cnt);
        return cnt == FCNT_W'(FAULT_FULL);
    endfunction : count_full

    // Every comparator crosses into the clock domain first
    lfm_sync u_sync_oc (.clk(clk), .reset(reset), .async_in(cmp_oc),
                        .sync_out(oc_s));
    lfm_sync u_sync_sc (.clk(clk), .reset(reset), .async_in(cmp_sc),
                        .sync_out(sc_s));
    lfm_sync u_sync_ov (.clk(clk), .reset(reset), .async_in(cmp_ov),
                        .sync_out(ov_s));
    lfm_sync u_sync_uv (.clk(clk), .reset(reset), .async_in(cmp_uv),
                        .sync_out(uv_s));
    lfm_sync u_sync_cl (.clk(clk), .reset(reset), .async_in(cmp_comp_low),
                        .sync_out(cl_s));

    // Retriggerable hold for over-current; reloads while comparator is high
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            oc_hold_q <= '0;
        end else if (oc_s) begin
            oc_hold_q <= HOLD_W'(HOLD_CYC);
        end else if (oc_hold_q != '0) begin
            oc_hold_q <= oc_hold_q - 1'b1;
        end
    end

    // Same one-shot for the over/under-voltage status
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ov_hold_q <= '0;
        end else if (ov_s || uv_s) begin
            ov_hold_q <= HOLD_W'(HOLD_CYC);
        end else if (ov_hold_q != '0) begin
            ov_hold_q <= ov_hold_q - 1'b1;
        end
    end

    assign oc_held   = (oc_hold_q != '0);
    assign ov_held   = (ov_hold_q != '0);
    // Expiry is the last count with the condition gone
    assign oc_expire = (oc_hold_q == HOLD_W'(1)) && !oc_s;
    assign ov_expire = (ov_hold_q == HOLD_W'(1)) && !ov_s && !uv_s;

    // Periodic reset schedule: first at 32768, then every 65536
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sched_q      <= '0;
            first_done_q <= 1'b0;
        end else if (sched_rst) begin
            sched_q      <= '0;
            first_done_q <= 1'b1;
        end else begin
            sched_q <= sched_q + 1'b1;
        end
    end
    assign sched_rst = first_done_q
                     ? (sched_q == SCHED_W'(PERIOD_RST - 1))
                     : (sched_q == SCHED_W'(FIRST_RST - 1));

    // Shared fault counter; advances once per drive-rate clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fcnt_q <= '0;
        end else if (count_full(fcnt_q)) begin
            fcnt_q <= fcnt_q; // Saturate once confirmed
        end else if (sched_rst || oc_expire || ov_expire) begin
            fcnt_q <= '0;
        end else if (oc_held || uv_s) begin
            fcnt_q <= fcnt_q + 1'b1;
        end
    end

    // Latched fault; only power-on reset clears it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_q <= 1'b0;
        end else if (sc_s || count_full(fcnt_q)) begin
            fault_q <= 1'b1;
        end
    end

    // Short circuit latch, live from reset release with no start-up mask
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sc_trip_q <= 1'b0;
        end else if (sc_s) begin
            sc_trip_q <= 1'b1;
        end
    end

    // Drive gating; uses the live sync so shutdown needs no extra cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drive_out_first  <= 1'b0;
            drive_out_second <= 1'b0;
        end else if (sc_s || sc_trip_q || cl_s) begin
            drive_out_first  <= 1'b0;
            drive_out_second <= 1'b0;
        end else begin
            drive_out_first  <= drive_in_first;
            drive_out_second <= drive_in_second;
        end
    end

    // Clamp follows the voltage comparator directly
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clamp_enable <= 1'b0;
        end else begin
            clamp_enable <= ov_s;
        end
    end

    assign fault_n = !fault_q;

    // Checks
    sc_kill_a: assert property (@(posedge clk) disable iff (reset)
        sc_s |=> !drive_out_first && !drive_out_second && !fault_n)
        else $error("short circuit did not stop drives");
    sc_live_a: assert property (@(posedge clk) disable iff (reset)
        sc_s |=> sc_trip_q)
        else $error("short circuit not latched");
    sc_latch_a: assert property (@(posedge clk) disable iff (reset)
        sc_trip_q |=> !drive_out_first && !drive_out_second)
        else $error("shutdown not latched");
    fault_latch_a: assert property (@(posedge clk) disable iff (reset)
        !fault_n |=> !fault_n)
        else $error("fault indicator released");
    comp_low_a: assert property (@(posedge clk) disable iff (reset)
        cl_s |=> !drive_out_first && !drive_out_second)
        else $error("drives on with error node low");
    drive_pass_a: assert property (@(posedge clk) disable iff (reset)
        !sc_s && !sc_trip_q && !cl_s
        |=> drive_out_first == $past(drive_in_first)
            && drive_out_second == $past(drive_in_second))
        else $error("drives not passed through while healthy");
    clamp_on_a: assert property (@(posedge clk) disable iff (reset)
        ov_s |=> clamp_enable)
        else $error("clamp not enabled at 2 V");
    oc_load_a: assert property (@(posedge clk) disable iff (reset)
        oc_s |=> oc_hold_q == HOLD_W'(HOLD_CYC))
        else $error("over-current hold not reloaded");
    oc_hold_a: assert property (@(posedge clk) disable iff (reset)
        $fell(oc_s) |-> oc_held [*8])
        else $error("over-current hold dropped early");
    ov_hold_a: assert property (@(posedge clk) disable iff (reset)
        $fell(ov_s || uv_s) |-> ov_held [*8])
        else $error("voltage hold dropped early");
    full_fault_a: assert property (@(posedge clk) disable iff (reset)
        fcnt_q == FCNT_W'(FAULT_FULL) |=> !fault_n)
        else $error("full count gave no fault");
    oc_clear_a: assert property (@(posedge clk) disable iff (reset)
        oc_expire && fcnt_q != FCNT_W'(FAULT_FULL) |=> fcnt_q == '0)
        else $error("counter not cleared on hold expiry");
    ov_clear_a: assert property (@(posedge clk) disable iff (reset)
        ov_expire && fcnt_q != FCNT_W'(FAULT_FULL) |=> fcnt_q == '0)
        else $error("counter not cleared on voltage hold expiry");
    sched_clear_a: assert property (@(posedge clk) disable iff (reset)
        sched_rst && fcnt_q != FCNT_W'(FAULT_FULL) |=> fcnt_q == '0)
        else $error("periodic reset missed");
    uv_count_a: assert property (@(posedge clk) disable iff (reset)
        uv_s && !sched_rst && !oc_expire && !ov_expire
        && fcnt_q < FCNT_W'(FAULT_FULL) |=> fcnt_q == $past(fcnt_q) + 1'b1)
        else $error("undervoltage did not count");

    sc_cov: cover property (@(posedge clk) disable iff (reset) $rose(sc_s));
    ov_clr_cov: cover property (@(posedge clk) disable iff (reset)
        ov_expire && fcnt_q != '0);
    full_cov: cover property (@(posedge clk) disable iff (reset)
        $fell(fault_n) && !sc_trip_q);
    expire_cov: cover property (@(posedge clk) disable iff (reset)
        oc_expire);
    clamp_cov: cover property (@(posedge clk) disable iff (reset)
        $rose(clamp_enable));
endmodule : lfm_fault_monitor

// ==== core/lfm_pkg.sv ====
package lfm_pkg;
    // Clock rate of the supervising logic
    localparam int unsigned CLK_MHZ        = 200;
    // Hold time of the over-current and over/under-voltage one-shots
    localparam int unsigned HOLD_US        = 50;
    localparam int unsigned HOLD_CYC       = HOLD_US * CLK_MHZ;
    localparam int unsigned HOLD_W         = 14;
    // Fault counter full count and periodic reset schedule
    localparam int unsigned FAULT_FULL     = 256;
    localparam int unsigned FIRST_RST      = 32768;
    localparam int unsigned PERIOD_RST     = 65536;
    localparam int unsigned FCNT_W         = 9;
    localparam int unsigned SCHED_W        = 17;
    // Synchroniser depth for comparator inputs
    localparam int unsigned SYNC_STAGES    = 3;
endpackage : lfm_pkg

// ==== core/lfm_sync.sv ====
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree
module lfm_sync
    import lfm_pkg::*;
(
    input  wire logic clk,      // Counter clock
    input  wire logic reset,    // Async reset, active high
    input  wire logic async_in, // Comparator level from outside
    output logic      sync_out  // Filtered level
);
    logic [SYNC_STAGES-1:0] stage_q;

    // Shift chain; stage 0 feeds only stage 1
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage_q <= '0;
        end else begin
            stage_q <= {stage_q[SYNC_STAGES-2:0], async_in};
        end
    end

    // Output moves only when the last two stages agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_out <= 1'b0;
        end else if (stage_q[1] == stage_q[2]) begin
            sync_out <= stage_q[2];
        end
    end
endmodule : lfm_sync

// ==== bench/lfm_analog_model.sv ====
`timescale 1ns/1ps
// Comparator bank and compensation node seen by the fault monitor
module lfm_analog_model (
    input  wire logic [15:0] isense_mv,    // Current sense level, mV
    input  wire logic [15:0] vsense_mv,    // Voltage sense level, mV
    input  wire logic [15:0] uvs_mv,       // Undervoltage/sync level, mV
    input  wire logic [15:0] comp_mv,      // Error amp node when unclamped
    input  wire logic        clamp_enable, // Clamp source from the monitor
    output logic             cmp_oc,       // Over-current comparator
    output logic             cmp_sc,       // Short-circuit comparator
    output logic             cmp_ov,       // Over-voltage comparator
    output logic             cmp_uv,       // Undervoltage comparator
    output logic             cmp_comp_low  // Error amp node low
);
    logic [15:0] node_mv; // Clamp drags the node well under 0.5 V
    // Clamp is ideal: it wins over the loop, so shutdown follows
    assign node_mv = clamp_enable ? 16'h012c : comp_mv;
    // Threshold comparators, levels only
    assign cmp_oc       = isense_mv > 16'h0276;
    assign cmp_sc       = isense_mv > 16'h03e8;
    assign cmp_ov       = vsense_mv >= 16'h07d0;
    assign cmp_uv       = uvs_mv < 16'h0190;
    assign cmp_comp_low = node_mv < 16'h01f4;
endmodule : lfm_analog_model

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic clk, reset, oc, sc, ov, uv, cl, din1, din2, dout1, dout2;
    logic clamp, fault_n;
    logic [15:0] isn, vsn, uvs, cmpv;
    int fail_count = 0;
    int n_compared = 0;
    // Free-running counter clock, 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    lfm_analog_model lfm_analog_model_inst (.isense_mv(isn), .vsense_mv(vsn),
        .uvs_mv(uvs), .comp_mv(cmpv), .clamp_enable(clamp), .cmp_oc(oc),
        .cmp_sc(sc), .cmp_ov(ov), .cmp_uv(uv), .cmp_comp_low(cl));
    lfm_fault_monitor lfm_fault_monitor_inst (.clk(clk), .reset(reset),
        .cmp_oc(oc), .cmp_sc(sc), .cmp_ov(ov), .cmp_uv(uv),
        .cmp_comp_low(cl), .drive_in_first(din1), .drive_in_second(din2),
        .drive_out_first(dout1), .drive_out_second(dout2),
        .clamp_enable(clamp), .fault_n(fault_n));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic check(input string what, input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    // Bounded wait; running out counts and ends the run
    task automatic wait_fault(input int lim);
        int i;
        i = 0;
        while (fault_n !== 1'b0 && i < lim) begin
            cyc(1);
            i++;
        end
        check("fault_n", fault_n, 1'b0);
        if (fault_n !== 1'b0) summarize();
    endtask : wait_fault
    // Quiet analog levels, six-cycle reset
    task automatic do_reset();
        reset = 1'b1;
        {isn, vsn, uvs, cmpv} = {16'h012c, 16'h03e8, 16'h03e8, 16'h09c4};
        cyc(6);
        check("fault_n rst", fault_n, 1'b1);
        check("clamp rst", clamp, 1'b0);
        check("drive rst", dout1 | dout2, 1'b0);
        reset = 1'b0;
    endtask : do_reset
    // Node low gates both drives, not latched; clamp chains into it
    task automatic t_gate_clamp();
        cyc(6);
        check("drive_out_first", dout1, 1'b1);
        check("drive_out_second", dout2, 1'b0);
        {din1, din2} = 2'b01;
        cyc(2);
        check("drive_out_first low", dout1, 1'b0);
        check("drive_out_second high", dout2, 1'b1);
        {din1, din2} = 2'b11;
        cmpv = 16'h0190;
        cyc(6);
        check("drive off low node", dout1 | dout2, 1'b0);
        cmpv = 16'h09c4;
        vsn = 16'h07d0;
        cyc(6);
        check("clamp_enable on", clamp, 1'b1);
        cyc(6);
        check("drive off clamped", dout1 | dout2, 1'b0);
        vsn = 16'h05dc;
        cyc(12);
        check("clamp_enable off", clamp, 1'b0);
        check("drive back", dout1 & dout2, 1'b1);
    endtask : t_gate_clamp
    // Short circuit straight after reset release, then gone again
    task automatic t_short();
        do_reset();
        isn = 16'h04b0;
        wait_fault(8);
        check("drive off short", dout1 | dout2, 1'b0);
        isn = 16'h012c;
        cyc(20);
        check("fault latched", fault_n, 1'b0);
        check("shutdown latched", dout1 | dout2, 1'b0);
    endtask : t_short
    // Brief over-current; hold keeps counting to full count
    task automatic t_oc_hold();
        do_reset();
        isn = 16'h02bc;
        cyc(10);
        isn = 16'h012c;
        cyc(230);
        check("fault before 256", fault_n, 1'b1);
        wait_fault(60);
        cyc(20);
        check("fault held", fault_n, 1'b0);
    endtask : t_oc_hold
    // Undervoltage count cleared by hold expiry, then resumed
    task automatic t_uv_hold();
        do_reset();
        uvs = 16'h012c;
        cyc(200);
        uvs = 16'h03e8;
        cyc(10100);
        uvs = 16'h012c;
        cyc(200);
        check("count cleared at expiry", fault_n, 1'b1);
        wait_fault(100);
    endtask : t_uv_hold
    // Undervoltage straddling the first scheduled clear
    task automatic t_sched();
        do_reset();
        cyc(32568);
        uvs = 16'h012c;
        cyc(400);
        check("scheduled clear", fault_n, 1'b1);
        wait_fault(100);
    endtask : t_sched
    initial begin
        {din1, din2} = 2'b10;
        do_reset();
        t_gate_clamp();
        t_short();
        t_oc_hold();
        t_uv_hold();
        t_sched();
        summarize();
    end
endmodule : testbench
